// *** inc/ccss_pkg.sv ***
// Shared constants and types of the CPU clock source switch block
package ccss_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;                 // aclk period at 250 MHz
    localparam int SWITCH_NS     = 16;                // Source change settle time
    localparam int CLK_HZ        = 250000000;         // aclk rate
    localparam int FX_HZ         = 10000000;          // Nominal crystal rate
    // Least time, rounded up to whole cycles
    localparam logic [2:0]  SWITCH_CYC = 3'((SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // aclk cycles standing for one crystal period
    localparam logic [15:0] FX_PRESCALE_DFLT = 16'(CLK_HZ / FX_HZ);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_RUN_CONTROL_OFS       = 8'h00;
    localparam logic [7:0] SYSTEM_CLOCK_SELECT_OFS     = 8'h04;
    localparam logic [7:0] SUBSYSTEM_SOURCE_SELECT_OFS = 8'h08;
    localparam logic [7:0] OSCILLATOR_MODE_CONFIG_OFS  = 8'h0C;
    localparam logic [7:0] SETTLE_TIME_SELECT_OFS      = 8'h10;
    localparam logic [7:0] SETTLE_COUNTER_STATUS_OFS   = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RUN_MAIN_XTAL_STOP   = 7;
    localparam int RUN_SUB_XTAL_STOP    = 6;
    localparam int RUN_MID_OSC_ENABLE   = 1;
    localparam int RUN_FAST_OSC_STOP    = 0;
    localparam int SEL_CPU_SOURCE_STAT  = 7;
    localparam int SEL_SUBSYSTEM_SELECT = 6;
    localparam int SEL_MAIN_SOURCE_STAT = 5;
    localparam int SEL_MAIN_BIT_ZERO    = 4;
    localparam int SEL_MID_SOURCE_STAT  = 1;
    localparam int SEL_MAIN_BIT_ONE     = 0;
    localparam int SUB_SLOW_OSC_SELECT  = 0;
    localparam int MODE_EXTERNAL_INPUT  = 7;
    localparam int MODE_PIN_XTAL        = 6;
    localparam int MODE_XTAL_GAIN       = 0;
    localparam int SETTLE_SEL_W         = 3;
    localparam int SETTLE_CNT_W         = 19;
    localparam int SETTLE_THRESHOLD_FIRST_BIT = 7;
    localparam int SETTLE_THRESHOLD_LAST_BIT  = 0;

    // ------------------------------------------------------------
    // Reset values and answers
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_RST        = 8'hC0;   // Both crystals stopped
    localparam logic [7:0] MODE_RST       = 8'h00;
    localparam logic [2:0] SETTLE_SEL_RST = 3'h7;    // Longest wait
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_ONE = 19'h00001;

    // Threshold exponents (crystal periods 2^n), MSB status bit first
    localparam logic [4:0] SETTLE_EXP [8] = '{5'h08, 5'h09, 5'h0A, 5'h0B,
                                              5'h0D, 5'h0F, 5'h11, 5'h12};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CCSS_SRC_FAST = 3'b001,                       // High-speed on-chip
        CCSS_SRC_MID  = 3'b010,                       // Middle-speed on-chip
        CCSS_SRC_XTAL = 3'b100                        // High-speed system clock
    } ccss_main_e;

    typedef struct packed {
        logic fast_en;                                // High-speed on-chip runs
        logic mid_en;                                 // Middle-speed on-chip runs
        logic slow_en;                                // Low-speed on-chip runs
        logic xtal_en;                                // X1 path runs
        logic sub_xtal_en;                            // XT1 path runs
    } ccss_osc_s;

    typedef struct packed {
        logic main_pin_xtal_mode;                     // Pins serve the main clock
        logic main_external_input;                    // External clock, no crystal
        logic main_xtal_gain;                         // High gain above 10 MHz
    } ccss_pin_s;

    typedef struct packed {
        logic main_xtal_stop;
        logic sub_xtal_stop;
        logic mid_osc_enable;
        logic fast_osc_stop;
    } ccss_run_s;

    typedef struct packed {
        logic                    aw_rdy;
        logic                    w_rdy;
        logic                    aw_got;
        logic                    w_got;
        logic [7:0]              aw_addr;
        logic [7:0]              w_data;
        logic                    w_stb0;
        logic                    b_vld;
        logic [1:0]              b_resp;
        logic                    ar_rdy;
        logic                    r_vld;
        logic [1:0]              r_resp;
        logic [7:0]              r_data;
        ccss_run_s               run;
        logic                    subsystem_select;
        logic                    main_select_bit_zero;
        logic                    main_select_bit_one;
        ccss_main_e              main_src;
        logic                    cpu_on_sub;
        logic                    slow_osc_select;
        logic [7:0]              mode_cfg;
        logic                    mode_locked;
        logic [2:0]              settle_sel;
        logic [15:0]             pre_cnt;
        logic [SETTLE_CNT_W-1:0] settle_cnt;
        logic [2:0]              sw_cnt;
        ccss_osc_s               osc;
        ccss_pin_s               pin;
    } ccss_state_s;

endpackage

// *** rtl/ccss_top.sv ***
// CPU clock source switch: oscillator control, source selection, AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

module ccss_top #(
    parameter logic [15:0] FX_PRESCALE = ccss_pkg::FX_PRESCALE_DFLT
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output ccss_pkg::ccss_osc_s       osc_ctl,
    output ccss_pkg::ccss_pin_s       pin_cfg,
    output ccss_pkg::ccss_main_e      main_src,
    output logic                      cpu_on_sub,
    output logic                      sub_from_slow
);
    import ccss_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ccss_state_s s_r;                          // Whole block state
    ccss_state_s s_nxt;                        // Its next value
    logic [7:0]  settle_stat;                  // Counter status byte
    logic        settle_done;                  // Selected wait reached
    logic        xtal_rdy;                     // X1 path usable
    logic        sub_rdy;                      // Subsystem source usable
    logic        tgt_rdy;                      // Wanted main source usable
    ccss_main_e  tgt_src;                      // Wanted main source
    logic [7:0]  rd_byte;                      // Read mux result
    logic        rd_hit;                       // Read address decoded

    // ------------------------------------------------------------
    // Settle counter status, one bit per threshold
    // ------------------------------------------------------------
    // Bits light from the MSB down as the count passes each of the eight SETTLE_EXP powers of two
    for (genvar i = 0; i < 8; i++) begin : g_thr
        assign settle_stat[SETTLE_THRESHOLD_FIRST_BIT - i] =
            (s_r.settle_cnt >= (SETTLE_ONE << SETTLE_EXP[i]));
    end

    // Wait length picked by the select field
    assign settle_done = (s_r.settle_cnt >= (SETTLE_ONE << SETTLE_EXP[s_r.settle_sel]));

    // External input needs no settling; crystal waits for the counter
    assign xtal_rdy = s_r.osc.xtal_en & (s_r.pin.main_external_input | settle_done);

    // Subsystem is fed by the low-speed oscillator or by XT1
    assign sub_rdy = s_r.slow_osc_select ? s_r.osc.slow_en : s_r.osc.sub_xtal_en;

    // ------------------------------------------------------------
    // Wanted main source and its readiness
    // ------------------------------------------------------------
    always_comb begin
        // Bit zero wins; bit one alone picks middle-speed
        if (s_r.main_select_bit_zero) begin
            tgt_src = CCSS_SRC_XTAL;
        end else if (s_r.main_select_bit_one) begin
            tgt_src = CCSS_SRC_MID;
        end else begin
            tgt_src = CCSS_SRC_FAST;
        end
        unique case (tgt_src)
            CCSS_SRC_FAST: tgt_rdy = s_r.osc.fast_en;
            CCSS_SRC_MID:  tgt_rdy = s_r.osc.mid_en;
            CCSS_SRC_XTAL: tgt_rdy = xtal_rdy;
            default:       tgt_rdy = 1'b0;                      // Illegal code
        endcase
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr & 8'hFC)
            CLOCK_RUN_CONTROL_OFS: begin
                rd_byte[RUN_MAIN_XTAL_STOP] = s_r.run.main_xtal_stop;
                rd_byte[RUN_SUB_XTAL_STOP]  = s_r.run.sub_xtal_stop;
                rd_byte[RUN_MID_OSC_ENABLE] = s_r.run.mid_osc_enable;
                rd_byte[RUN_FAST_OSC_STOP]  = s_r.run.fast_osc_stop;
            end
            SYSTEM_CLOCK_SELECT_OFS: begin
                // Status bits show the source really in use
                rd_byte[SEL_CPU_SOURCE_STAT]  = s_r.cpu_on_sub;
                rd_byte[SEL_SUBSYSTEM_SELECT] = s_r.subsystem_select;
                rd_byte[SEL_MAIN_SOURCE_STAT] = (s_r.main_src == CCSS_SRC_XTAL);
                rd_byte[SEL_MAIN_BIT_ZERO]    = s_r.main_select_bit_zero;
                rd_byte[SEL_MID_SOURCE_STAT]  = (s_r.main_src == CCSS_SRC_MID);
                rd_byte[SEL_MAIN_BIT_ONE]     = s_r.main_select_bit_one;
            end
            SUBSYSTEM_SOURCE_SELECT_OFS: begin
                rd_byte[SUB_SLOW_OSC_SELECT] = s_r.slow_osc_select;
            end
            OSCILLATOR_MODE_CONFIG_OFS: begin
                rd_byte = s_r.mode_cfg;
            end
            SETTLE_TIME_SELECT_OFS: begin
                rd_byte[SETTLE_SEL_W-1:0] = s_r.settle_sel;
            end
            SETTLE_COUNTER_STATUS_OFS: begin
                rd_byte = settle_stat;
            end
            default: begin
                rd_hit = 1'b0;                                  // Unmapped
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Address and data channels are taken independently
        if (s_r.aw_rdy && s_axi_awvalid) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr & 8'hFC;
        end
        if (s_r.w_rdy && s_axi_wvalid) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_stb0 = s_axi_wstrb[0];
        end
        if (s_r.b_vld && s_axi_bready) begin
            s_nxt.b_vld = 1'b0;
        end

        // Perform the write once both halves are held
        if (s_r.aw_got && s_r.w_got) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.b_vld  = 1'b1;
            s_nxt.b_resp = RESP_OKAY;
            unique case (s_r.aw_addr)
                CLOCK_RUN_CONTROL_OFS: begin
                    if (s_r.w_stb0) begin
                        s_nxt.run.main_xtal_stop = s_r.w_data[RUN_MAIN_XTAL_STOP];
                        s_nxt.run.sub_xtal_stop  = s_r.w_data[RUN_SUB_XTAL_STOP];
                        s_nxt.run.mid_osc_enable = s_r.w_data[RUN_MID_OSC_ENABLE];
                        s_nxt.run.fast_osc_stop  = s_r.w_data[RUN_FAST_OSC_STOP];
                    end
                end
                SYSTEM_CLOCK_SELECT_OFS: begin
                    if (s_r.w_stb0) begin
                        s_nxt.subsystem_select = s_r.w_data[SEL_SUBSYSTEM_SELECT];
                        // Main select frozen while the subsystem is selected
                        if (!s_r.subsystem_select) begin
                            s_nxt.main_select_bit_zero = s_r.w_data[SEL_MAIN_BIT_ZERO];
                            s_nxt.main_select_bit_one  = s_r.w_data[SEL_MAIN_BIT_ONE];
                        end
                    end
                end
                SUBSYSTEM_SOURCE_SELECT_OFS: begin
                    // Not guarded: keeping off it while on subsystem is up to software
                    if (s_r.w_stb0) begin
                        s_nxt.slow_osc_select = s_r.w_data[SUB_SLOW_OSC_SELECT];
                    end
                end
                OSCILLATOR_MODE_CONFIG_OFS: begin
                    // Any write carrying the low byte uses up the one chance
                    if (s_r.w_stb0 && !s_r.mode_locked) begin
                        s_nxt.mode_cfg    = s_r.w_data;
                        s_nxt.mode_locked = 1'b1;
                    end
                end
                SETTLE_TIME_SELECT_OFS: begin
                    if (s_r.w_stb0) begin
                        s_nxt.settle_sel = s_r.w_data[SETTLE_SEL_W-1:0];
                    end
                end
                SETTLE_COUNTER_STATUS_OFS: begin
                    // Read only; write accepted and dropped
                end
                default: begin
                    s_nxt.b_resp = RESP_SLVERR;
                end
            endcase
        end
        s_nxt.aw_rdy = !s_nxt.aw_got && !s_nxt.b_vld;
        s_nxt.w_rdy  = !s_nxt.w_got && !s_nxt.b_vld;

        // Read channel: one read at a time
        if (s_r.r_vld && s_axi_rready) begin
            s_nxt.r_vld = 1'b0;
        end
        if (s_r.ar_rdy && s_axi_arvalid) begin
            s_nxt.r_vld  = 1'b1;
            s_nxt.r_data = rd_byte;
            s_nxt.r_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        s_nxt.ar_rdy = !s_nxt.r_vld;

        // Oscillator run controls follow the register bits
        s_nxt.osc.fast_en     = !s_r.run.fast_osc_stop;
        s_nxt.osc.mid_en      = s_r.run.mid_osc_enable;
        s_nxt.osc.slow_en     = s_r.slow_osc_select;
        s_nxt.osc.sub_xtal_en = !s_r.run.sub_xtal_stop;
        // X1 runs only when the pins are given to the main clock
        s_nxt.osc.xtal_en = !s_r.run.main_xtal_stop && s_r.pin.main_pin_xtal_mode;

        // Pin configuration from the one-time mode byte
        s_nxt.pin.main_pin_xtal_mode  = s_r.mode_cfg[MODE_PIN_XTAL];
        s_nxt.pin.main_external_input = s_r.mode_cfg[MODE_EXTERNAL_INPUT]
                                        && s_r.mode_cfg[MODE_PIN_XTAL];
        s_nxt.pin.main_xtal_gain      = s_r.mode_cfg[MODE_XTAL_GAIN];

        // Crystal settle counter: cleared while stopped or on external input
        if (!s_r.osc.xtal_en || s_r.pin.main_external_input) begin
            s_nxt.pre_cnt    = 16'h0000;
            s_nxt.settle_cnt = '0;
        end else if (!settle_done) begin
            if (s_r.pre_cnt >= FX_PRESCALE - 16'h0001) begin
                s_nxt.pre_cnt    = 16'h0000;
                s_nxt.settle_cnt = s_r.settle_cnt + SETTLE_ONE;
            end else begin
                s_nxt.pre_cnt = s_r.pre_cnt + 16'h0001;
            end
        end

        // Source change: the new source takes over after a short settle,
        // and only when it is actually running, except on a return from the subsystem to the main source
        if ((tgt_src != s_r.main_src && tgt_rdy) ||
            (s_r.subsystem_select != s_r.cpu_on_sub &&
             (s_r.subsystem_select ? sub_rdy : 1'b1))) begin
            if (s_r.sw_cnt >= SWITCH_CYC - 3'h1) begin
                s_nxt.sw_cnt = 3'h0;
                if (tgt_rdy) begin
                    s_nxt.main_src = tgt_src;
                end
                if (!s_r.subsystem_select || sub_rdy) begin
                    s_nxt.cpu_on_sub = s_r.subsystem_select;
                end
            end else begin
                s_nxt.sw_cnt = s_r.sw_cnt + 3'h1;
            end
        end else begin
            s_nxt.sw_cnt = 3'h0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r                      <= '0;
            // Run bits taken straight from the reset byte, field by field
            s_r.run                  <= {RUN_RST[RUN_MAIN_XTAL_STOP], RUN_RST[RUN_SUB_XTAL_STOP],
                                         RUN_RST[RUN_MID_OSC_ENABLE], RUN_RST[RUN_FAST_OSC_STOP]};
            s_r.mode_cfg             <= MODE_RST;
            s_r.settle_sel           <= SETTLE_SEL_RST;
            s_r.main_src             <= CCSS_SRC_FAST;
            s_r.osc.fast_en          <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from the state register
    // ------------------------------------------------------------
    assign s_axi_awready = s_r.aw_rdy;
    assign s_axi_wready  = s_r.w_rdy;
    assign s_axi_bvalid  = s_r.b_vld;
    assign s_axi_bresp   = s_r.b_resp;
    assign s_axi_arready = s_r.ar_rdy;
    assign s_axi_rvalid  = s_r.r_vld;
    assign s_axi_rresp   = s_r.r_resp;
    assign s_axi_rdata   = {24'h000000, s_r.r_data};
    assign osc_ctl       = s_r.osc;
    assign pin_cfg       = s_r.pin;
    assign main_src      = s_r.main_src;
    assign cpu_on_sub    = s_r.cpu_on_sub;
    assign sub_from_slow = s_r.slow_osc_select;

endmodule

`default_nettype wire

// *** verif/ccss_assertions.sv ***
// Port checker of the CPU clock source switch
`timescale 1ns/10ps
`default_nettype none
module ccss_checker (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_rvalid,
    input wire logic [31:0]          s_axi_rdata,
    input wire ccss_pkg::ccss_osc_s  osc_ctl,
    input wire ccss_pkg::ccss_pin_s  pin_cfg,
    input wire ccss_pkg::ccss_main_e main_src,
    input wire logic                 cpu_on_sub,
    input wire logic                 sub_from_slow
);
    import ccss_pkg::*;
    // ----------------------------------------
    // Source-in-use versus running oscillators, pin lock and bus checks
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A middle-speed or crystal source in use must never be stopped; a subsystem feed must run when entered
    property p_mid; main_src == CCSS_SRC_MID |-> osc_ctl.mid_en; endproperty
    a_mid: assert property (p_mid) else $error("mid source in use but stopped");
    property p_xtal; main_src == CCSS_SRC_XTAL |-> osc_ctl.xtal_en; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal in use but stopped");
    property p_sub; $rose(cpu_on_sub) |-> osc_ctl.slow_en || osc_ctl.sub_xtal_en; endproperty
    a_sub: assert property (p_sub) else $error("cpu moved to dead subsystem");
    // Run control lags the select bit by one register stage
    property p_slow; sub_from_slow && $past(sub_from_slow) |-> osc_ctl.slow_en; endproperty
    a_slow: assert property (p_slow) else $error("slow feed while slow stopped");
    property p_pin; osc_ctl.xtal_en |-> pin_cfg.main_pin_xtal_mode; endproperty
    a_pin: assert property (p_pin) else $error("crystal runs on non-crystal pins");
    // Nonzero pin setup means the one allowed write has happened
    property p_lock; pin_cfg != 3'b000 |=> $stable(pin_cfg); endproperty
    a_lock: assert property (p_lock) else $error("mode config changed twice");
    property p_hot; $onehot(main_src); endproperty
    a_hot: assert property (p_hot) else $error("main source not one-hot");
    property p_rdat; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_rdat: assert property (p_rdat) else $error("read data upper bits set");
    property p_bwait; $rose(s_axi_bvalid) |-> !s_axi_awready; endproperty
    a_bwait: assert property (p_bwait) else $error("address taken during response");
endmodule
bind ccss_top ccss_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
    .s_axi_rvalid, .s_axi_rdata, .osc_ctl, .pin_cfg, .main_src, .cpu_on_sub, .sub_from_slow);
`default_nettype wire

// *** verif/test_cpu_clock_source_switch.sv ***
// Self-checking bench of the CPU clock source switch
`timescale 1ns/10ps
`default_nettype none
module test_cpu_clock_source_switch;
    import ccss_pkg::*;
    // ----------------------------------------
    // Stimulus, responses and table
    // ----------------------------------------
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb = 0;
    logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    ccss_osc_s   osc_ctl;
    ccss_pin_s   pin_cfg;
    ccss_main_e  main_src;
    logic        cpu_on_sub, sub_from_slow;
    int          err_count = 0, n_tests = 0, cyc = 0;
    // Rows: address, write byte, expected read byte, expected response
    logic [31:0] rows [5] = '{32'h10050500,
                              32'h14FF0000, 32'h08000000,
                              32'h3C110002,  // Unmapped place
                              32'h00C2C200};
    logic [7:0]  rst_v [6] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
    // Prescale of one keeps the settle wait near a thousand cycles
    ccss_top #(.FX_PRESCALE(16'h0001)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_ctl, .pin_cfg, .main_src, .cpu_on_sub,
        .sub_from_slow);
    always #2 aclk = ~aclk;
    // Hang guard, far above the roughly 1200 cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            err_count++;
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata; rsp = s_axi_rresp;
    endtask
    // Poll a register as software would, bounded
    task automatic pl(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        int k;
        k = 0;
        do begin rd(a); k++; end while ((rdat[7:0] & m) !== e && k < 400);
        chk({24'h0, rdat[7:0] & m}, {24'h0, e});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[j]) begin
            wr(rows[j][31:24], rows[j][23:16]);
            chk(rsp, rows[j][1:0]);
            rd(rows[j][31:24]);
            chk(rsp, rows[j][1:0]);
            if (rows[j][1:0] == RESP_OKAY) chk(rdat, rows[j][15:8]);
        end
        @(negedge aclk) chk(osc_ctl.mid_en, 1'b1);
        $display("test table done");
        // Software-timed settle of the on-chip oscillator before selecting it
        repeat (8) @(posedge aclk);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h01);
        pl(SYSTEM_CLOCK_SELECT_OFS, 8'h22, 8'h02);
        chk(main_src, CCSS_SRC_MID);
        wr(CLOCK_RUN_CONTROL_OFS, 8'hC3);
        @(negedge aclk) chk(osc_ctl.fast_en, 1'b0);
        wr(CLOCK_RUN_CONTROL_OFS, 8'hC2);
        @(negedge aclk) chk(osc_ctl.fast_en, 1'b1);
        $display("test middle done");
        wr(SUBSYSTEM_SOURCE_SELECT_OFS, 8'h01);
        @(negedge aclk) chk({osc_ctl.slow_en, sub_from_slow}, 2'b11);
        repeat (8) @(posedge aclk);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h41);
        pl(SYSTEM_CLOCK_SELECT_OFS, 8'h80, 8'h80);
        chk(cpu_on_sub, 1'b1);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h50);
        rd(SYSTEM_CLOCK_SELECT_OFS);
        chk(rdat & 32'h51, 32'h41);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h01);
        pl(SYSTEM_CLOCK_SELECT_OFS, 8'hC3, 8'h03);
        $display("test subsystem done");
        wr(OSCILLATOR_MODE_CONFIG_OFS, 8'h41);
        @(negedge aclk) chk(pin_cfg, 3'b101);
        wr(OSCILLATOR_MODE_CONFIG_OFS, 8'hC0);
        rd(OSCILLATOR_MODE_CONFIG_OFS);
        chk(rdat, 32'h41);
        wr(SETTLE_TIME_SELECT_OFS, 8'h02);
        wr(CLOCK_RUN_CONTROL_OFS, 8'h42);
        @(negedge aclk) chk(osc_ctl.xtal_en, 1'b1);
        pl(SETTLE_COUNTER_STATUS_OFS, 8'hFF, 8'hE0);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h10);
        pl(SYSTEM_CLOCK_SELECT_OFS, 8'h20, 8'h20);
        chk(main_src, CCSS_SRC_XTAL);
        $display("test crystal done");
        // Second reset mid-run, then reset values and external input
        @(posedge aclk) aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_v[j]) begin
            rd(8'(4 * j));
            chk(rdat, {24'h0, rst_v[j]});
        end
        wr(OSCILLATOR_MODE_CONFIG_OFS, 8'hC0);
        @(negedge aclk) chk(pin_cfg, 3'b110);
        wr(CLOCK_RUN_CONTROL_OFS, 8'h40);
        wr(SYSTEM_CLOCK_SELECT_OFS, 8'h10);
        pl(SYSTEM_CLOCK_SELECT_OFS, 8'h20, 8'h20);
        $display("test external done");
        test_done;
    end
endmodule
`default_nettype wire
